// file: logic/vid_seq_pkg.sv
// Constants, encodings and the state type shared by the reference sequencer files.
package vid_seq_pkg;
   // Clock and switching rates; the switching period is counted in pclk cycles.
   localparam int PCLK_KHZ = 25000;
   localparam int SWITCH_KHZ = 222;
   localparam int CLKS_PER_SWITCH = PCLK_KHZ / SWITCH_KHZ;
   // Code sampling and validation.
   localparam int SAMPLES_FIVE = 4;
   localparam int SAMPLES_SIX = 6;
   localparam int STABLE_FIVE_CYCLES = 12;
   localparam int STABLE_SIX_READS = 3;
   localparam int STEP_SW_CYCLES = 4;
   // Soft-start timing, in switching cycles; the delay is about 70 us at 222 kHz.
   localparam int SS_DELAY_US = 70;
   localparam int SS_DELAY_SW_CYCLES = 16;
   localparam int SS_STEP_SW_CYCLES = 16;
   // Reference levels are in units of 12.5 mV.
   localparam int REF_UNIT_UV = 12500;
   localparam logic [7:0] REF_STEP_FIVE = 8'h02;
   localparam logic [7:0] BASE_LEGACY = 8'h58;
   localparam logic [7:0] BASE_ALT = 8'h40;
   localparam logic [7:0] BASE_SIX = 8'h43;
   localparam logic [5:0] SIX_LEVEL_OFFSET = 6'h15;
   localparam logic [7:0] OV_FIXED_LOW = 8'h84;
   localparam logic [7:0] OV_FIXED_HIGH = 8'h9c;
   localparam logic [7:0] OV_MARGIN = 8'h10;
   localparam logic [4:0] CODE_RESERVED = 5'h1f;
   localparam logic [5:0] CODE_RESET = 6'h3f;
   // Table selection encodings.
   localparam logic [1:0] TABLE_LEGACY = 2'h0;
   localparam logic [1:0] TABLE_ALT = 2'h1;
   localparam logic [1:0] TABLE_SIX = 2'h2;
   // Register map and fields.
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam int CTRL_RUN_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_DRIVES_BIT = 2;
   localparam int ST_CLAMP_BIT = 3;
   localparam int ST_REF_LSB = 8;
   localparam int ST_CODE_LSB = 16;
   localparam int ST_TABLE_LSB = 24;

   typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_RAMP, ST_RUN} seq_state_t;
endpackage : vid_seq_pkg

// file: logic/vid_filter_if.sv
// Signals between the sequencer and its code validation filter.
`timescale 1ns/100ps
interface vid_filter_if;
   logic sample_tick;
   logic sw_tick;
   logic six_mode;
   logic [5:0] raw_code;
   logic [5:0] accepted_code;
   logic new_code;

   modport filter (input sample_tick, input sw_tick, input six_mode, input raw_code,
      output accepted_code, output new_code);
   modport seq (output sample_tick, output sw_tick, output six_mode, output raw_code,
      input accepted_code, input new_code);
endinterface : vid_filter_if

// file: logic/vid_code_filter.sv
// Validation filter that accepts a voltage identification code once it is stable.
`timescale 1ns/100ps
module vid_code_filter
   import vid_seq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   vid_filter_if.filter vf
);
   logic [5:0] last_code;
   logic [3:0] stable_cnt;
   logic [5:0] sample_code;
   logic [3:0] need;

   // In five-bit use the sixth pin is ignored so that it cannot block acceptance.
   assign sample_code = vf.six_mode ? vf.raw_code : {1'b0, vf.raw_code[4:0]};
   assign need = vf.six_mode ? 4'(STABLE_SIX_READS) : 4'(STABLE_FIVE_CYCLES);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_code <= CODE_RESET;
         stable_cnt <= 4'h0;
      end else if (vf.sample_tick && sample_code != last_code) begin
         last_code <= sample_code;
         stable_cnt <= vf.six_mode ? 4'h1 : 4'h0;
      end else if (vf.six_mode && vf.sample_tick && stable_cnt < need) begin
         stable_cnt <= stable_cnt + 4'h1;
      end else if (!vf.six_mode && vf.sw_tick && stable_cnt < need) begin
         stable_cnt <= stable_cnt + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vf.accepted_code <= CODE_RESET;
         vf.new_code <= 1'b0;
      end else if (stable_cnt == need && last_code != vf.accepted_code) begin
         vf.accepted_code <= last_code;
         vf.new_code <= 1'b1;
      end else begin
         vf.new_code <= 1'b0;
      end
   end

   a_accept_when_stable: assert property (@(posedge pclk) disable iff (!presetn)
      vf.new_code |-> $past(stable_cnt) == $past(need))
      else $error("code accepted before it was stable");
endmodule : vid_code_filter

// file: logic/vid_reference_sequencer.sv
// Reference sequencer: code tracking, soft-start, start gating and overvoltage clamp.
//
// Behaviour
// - Five-bit tables: sample code four times per cycle.
// - Five-bit: accept code stable twelve switching cycles.
// - Five-bit: one reference step every four cycles.
// - Six-bit: six samples, accept after three reads.
// - Six-bit: reference jumps straight to new code.
// - Below supply reset level, low-side outputs float.
// - After reset, overvoltage turns low-side switches on.
// - Soft-start threshold: larger of fixed, code+200mV.
// - Clamp releases only below comparator hysteresis threshold.
// - Overvoltage never latches; regulation resumes automatically.
// - Either supply low: no start, switches off.
// - All-ones on code bits 4:0 disables; other codes start up.
// - All start conditions met: soft-start begins immediately.
// - Wait sixteen switching cycles before ramping.
// - Ramp 12.5mV every sixteen cycles to setting.
// - Drives held off until reference exceeds feedback.
// - Pre-charged above setting: drives on at end.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module vid_reference_sequencer
   import vid_seq_pkg::*;
#(
   parameter int PHASES = 2,
   parameter int CLKS_PER_SW = CLKS_PER_SWITCH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] voltage_id_code,
   input wire logic [1:0] table_select,
   input wire logic vcc_por_ok,
   input wire logic driver_supply_level_ok,
   input wire logic threshold_enable_input,
   input wire logic fb_below_ref,
   input wire logic overvoltage_comp,
   output logic [7:0] reference_setpoint,
   output logic [7:0] ov_threshold,
   output logic pwm_enable,
   output logic overvoltage_clamp,
   output logic [PHASES-1:0] low_side_gate_drive,
   output logic [PHASES-1:0] low_side_gate_drive_oe
);
   vid_filter_if vf ();

   seq_state_t state;
   logic [31:0] ctrl;
   logic [1:0] table_q;
   logic six_mode;
   logic [7:0] sw_div;
   logic [7:0] smp_at;
   logic [2:0] smp_num;
   logic [3:0] tick_cnt;
   logic ss_tick;
   logic step_tick;
   logic reserved;
   logic start_ok;
   logic drives_on;
   logic [4:0] lvl5;
   logic [5:0] lvl6;
   logic [7:0] target;
   logic [7:0] fixed_ov;
   logic [7:0] dac_ov;
   logic [7:0] dly_ticks;
   logic [31:0] status;

   // Switching cycle and code sampling strobes.
   assign six_mode = (table_q == TABLE_SIX);
   assign vf.sw_tick = (sw_div == 8'(CLKS_PER_SW - 1));
   assign vf.six_mode = six_mode;
   assign vf.raw_code = voltage_id_code;
   assign vf.sample_tick = (sw_div == smp_at) &&
      (smp_num < (six_mode ? 3'(SAMPLES_SIX) : 3'(SAMPLES_FIVE)));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_div <= 8'h00;
      end else begin
         sw_div <= vf.sw_tick ? 8'h00 : sw_div + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_at <= 8'h00;
         smp_num <= 3'h0;
      end else if (vf.sw_tick) begin
         smp_at <= 8'h00;
         smp_num <= 3'h0;
      end else if (vf.sample_tick) begin
         smp_at <= smp_at + (six_mode ? 8'(CLKS_PER_SW / SAMPLES_SIX) :
            8'(CLKS_PER_SW / SAMPLES_FIVE));
         smp_num <= smp_num + 3'h1;
      end
   end

   vid_code_filter u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .vf(vf.filter)
   );

   // Code to reference level; tables count down in voltage as the code rises.
   assign lvl5 = 5'(~vf.accepted_code[4:0] - 5'h01);
   assign lvl6 = 6'(~{vf.accepted_code[4:0], vf.accepted_code[5]} + SIX_LEVEL_OFFSET);

   always_comb begin
      case (table_q)
         TABLE_SIX: target = BASE_SIX + {2'h0, lvl6};
         TABLE_ALT: target = BASE_ALT + {2'h0, lvl5, 1'b0};
         default: target = BASE_LEGACY + {2'h0, lvl5, 1'b0};
      endcase
   end

   // Start gating; supply, enable and comparator levels are already synchronous.
   assign reserved = (vf.accepted_code[4:0] == CODE_RESERVED);
   assign start_ok = vcc_por_ok && driver_supply_level_ok && threshold_enable_input &&
      ctrl[CTRL_RUN_BIT] && !reserved;

   // Table choice is frozen once started, so a live change cannot warp the reference.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_q <= TABLE_LEGACY;
      end else if (state == ST_OFF) begin
         table_q <= table_select;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 4'h0;
      end else if (state == ST_OFF) begin
         tick_cnt <= 4'h0;
      end else if (vf.sw_tick) begin
         tick_cnt <= tick_cnt + 4'h1;
      end
   end
   assign ss_tick = vf.sw_tick && (tick_cnt == 4'(SS_STEP_SW_CYCLES - 1));
   assign step_tick = vf.sw_tick && (tick_cnt[1:0] == 2'(STEP_SW_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_OFF;
      end else if (!start_ok) begin
         state <= ST_OFF;
      end else begin
         case (state)
            ST_OFF: state <= ST_DELAY;
            ST_DELAY: begin
               if (vf.sw_tick && tick_cnt == 4'(SS_DELAY_SW_CYCLES - 1)) begin
                  state <= ST_RAMP;
               end
            end
            ST_RAMP: begin
               if (reference_setpoint >= target) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: state <= ST_RUN;
            default: state <= ST_OFF;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_setpoint <= 8'h00;
      end else if (state == ST_OFF || state == ST_DELAY) begin
         reference_setpoint <= 8'h00;
      end else if (state == ST_RAMP) begin
         if (ss_tick && reference_setpoint < target) begin
            reference_setpoint <= reference_setpoint + 8'h01;
         end
      end else if (six_mode) begin
         reference_setpoint <= target;
      end else if (step_tick && reference_setpoint < target) begin
         reference_setpoint <= (target - reference_setpoint > REF_STEP_FIVE) ?
            reference_setpoint + REF_STEP_FIVE : target;
      end else if (step_tick && reference_setpoint > target) begin
         reference_setpoint <= (reference_setpoint - target > REF_STEP_FIVE) ?
            reference_setpoint - REF_STEP_FIVE : target;
      end
   end

   // Drives stay off over a pre-charged output so soft-start does not sink it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drives_on <= 1'b0;
      end else if (state == ST_OFF || state == ST_DELAY) begin
         drives_on <= 1'b0;
      end else if (state == ST_RAMP && fb_below_ref) begin
         drives_on <= 1'b1;
      end else if (state == ST_RAMP && reference_setpoint >= target) begin
         drives_on <= 1'b1;
      end
   end

   // Overvoltage threshold and clamp; the clamp follows the comparator, never latching.
   assign fixed_ov = (table_q == TABLE_LEGACY) ? OV_FIXED_HIGH : OV_FIXED_LOW;
   assign dac_ov = 8'(target + OV_MARGIN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_threshold <= OV_FIXED_HIGH;
         overvoltage_clamp <= 1'b0;
         pwm_enable <= 1'b0;
      end else begin
         if (state == ST_RUN) begin
            ov_threshold <= dac_ov;
         end else if (state == ST_OFF) begin
            ov_threshold <= fixed_ov;
         end else begin
            ov_threshold <= (dac_ov > fixed_ov) ? dac_ov : fixed_ov;
         end
         overvoltage_clamp <= vcc_por_ok && overvoltage_comp;
         pwm_enable <= start_ok && drives_on && !overvoltage_comp &&
            (state == ST_RAMP || state == ST_RUN);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < PHASES; gi++) begin : g_phase
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               low_side_gate_drive[gi] <= 1'b0;
               low_side_gate_drive_oe[gi] <= 1'b0;
            end else begin
               low_side_gate_drive[gi] <= vcc_por_ok && overvoltage_comp;
               low_side_gate_drive_oe[gi] <= vcc_por_ok;
            end
         end
      end
   endgenerate

   // Register slave: zero wait states, read data captured in the setup cycle.
   assign status = {6'h00, table_q, 2'h0, vf.accepted_code, reference_setpoint,
      4'h0, overvoltage_clamp, drives_on, state};
   assign pready = 1'b1;
   assign pslverr = psel && penable && paddr != ADDR_CTRL && paddr != ADDR_STATUS;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
      end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
         ctrl <= {31'h0, pwdata[CTRL_RUN_BIT]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            ADDR_CTRL: prdata <= ctrl;
            ADDR_STATUS: prdata <= status;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_ticks <= 8'h00;
      end else if (state != ST_DELAY) begin
         dly_ticks <= 8'h00;
      end else if (vf.sw_tick) begin
         dly_ticks <= dly_ticks + 8'h01;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pre_por_float: assert property (!vcc_por_ok |=> low_side_gate_drive_oe == '0)
      else $error("low-side outputs driven below supply reset level");
   a_ov_clamp_on: assert property (vcc_por_ok && overvoltage_comp |=>
      overvoltage_clamp && low_side_gate_drive == '1 && !pwm_enable)
      else $error("overvoltage did not clamp");
   a_ov_no_latch: assert property ($fell(overvoltage_comp) && state == ST_RUN && start_ok
      |=> !overvoltage_clamp && state == ST_RUN)
      else $error("overvoltage latched the controller");
   a_supply_no_start: assert property (!(vcc_por_ok && driver_supply_level_ok) |=>
      state == ST_OFF ##1 !pwm_enable)
      else $error("started without supplies");
   a_reserved_off: assert property (reserved |=> state == ST_OFF)
      else $error("reserved code did not disable");
   a_start_now: assert property (state == ST_OFF && start_ok |=> state == ST_DELAY)
      else $error("soft-start not begun at once");
   a_delay_length: assert property (state == ST_RAMP && $past(state) == ST_DELAY |->
      dly_ticks == 8'd16)
      else $error("soft-start delay wrong");
   a_ramp_rate: assert property (state == ST_RAMP && $changed(reference_setpoint) |->
      $past(ss_tick) && reference_setpoint == $past(reference_setpoint) + 8'h01)
      else $error("ramp step or pace wrong");
   a_hold_precharged: assert property (state == ST_RAMP && !drives_on |=> !pwm_enable)
      else $error("drives enabled over pre-charged output");
   a_end_enable: assert property (state == ST_RUN |-> drives_on)
      else $error("drives not enabled at soft-start end");
   a_five_step: assert property (state == ST_RUN && !six_mode && $changed(reference_setpoint)
      && $past(state) == ST_RUN |-> $past(step_tick))
      else $error("five-bit step off pace");
   a_six_jump: assert property (state == ST_RUN && six_mode && vf.new_code && start_ok
      |=> ##1 reference_setpoint == $past(target))
      else $error("six-bit reference did not jump");
   a_ov_soft_thresh: assert property (state == ST_RAMP |=>
      ov_threshold >= fixed_ov || $past(state) != ST_RAMP)
      else $error("soft-start threshold below fixed level");

   c_ramp_done: cover property (state == ST_RAMP ##1 state == ST_RUN);
   c_six_jump: cover property (state == ST_RUN && six_mode && vf.new_code);
   c_five_step: cover property (state == ST_RUN && !six_mode && step_tick &&
      reference_setpoint != target);
   c_ov_clamp: cover property (state == ST_RUN && overvoltage_clamp ##1 !overvoltage_clamp);
endmodule : vid_reference_sequencer

// file: tb/vid_host_model.sv
// Processor-side model that presents the voltage identification code.
`timescale 1ns/100ps
module vid_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [5:0] req_code,
   output logic [5:0] voltage_id_code
);
   // The code starts all-ones, like a processor that has no load to announce yet.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_id_code <= 6'h3f;
      end else if (load) begin
         voltage_id_code <= req_code;
      end
   end
endmodule : vid_host_model

// file: tb/vid_reference_sequencer_tb.sv
// Self-checking testbench for the reference sequencer.
`timescale 1ns/100ps
module vid_reference_sequencer_tb;
   import vid_seq_pkg::*;
   localparam int SW = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [5:0] voltage_id_code;
   logic [1:0] table_select = 2'h0;
   logic vcc_por_ok = 1'b1;
   logic driver_supply_level_ok = 1'b1;
   logic threshold_enable_input = 1'b1;
   logic fb_below_ref = 1'b0;
   logic overvoltage_comp = 1'b0;
   logic [7:0] reference_setpoint;
   logic [7:0] ov_threshold;
   logic pwm_enable;
   logic overvoltage_clamp;
   logic [1:0] low_side_gate_drive;
   logic [1:0] low_side_gate_drive_oe;
   logic load = 1'b0;
   logic [5:0] req_code = 6'h3f;
   logic [31:0] r;
   logic e;
   int n;
   int n_mismatch = 0;
   int n_tests = 0;

   always #20 pclk = ~pclk;

   vid_host_model i_host (.pclk(pclk), .presetn(presetn), .load(load), .req_code(req_code),
      .voltage_id_code(voltage_id_code));

   vid_reference_sequencer #(.PHASES(2), .CLKS_PER_SW(SW)) i_dut (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .voltage_id_code(voltage_id_code), .table_select(table_select),
      .vcc_por_ok(vcc_por_ok), .driver_supply_level_ok(driver_supply_level_ok),
      .threshold_enable_input(threshold_enable_input), .fb_below_ref(fb_below_ref),
      .overvoltage_comp(overvoltage_comp), .reference_setpoint(reference_setpoint),
      .ov_threshold(ov_threshold), .pwm_enable(pwm_enable),
      .overvoltage_clamp(overvoltage_clamp), .low_side_gate_drive(low_side_gate_drive),
      .low_side_gate_drive_oe(low_side_gate_drive_oe));

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // Requests are held until pready is seen high, so a slower slave still works.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
         output logic [31:0] rdata, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so that the next request never re-drives psel in this time step.
      @(posedge pclk);
   endtask : apb

   task automatic rd_st(output logic [31:0] s);
      logic err;
      apb(1'b0, ADDR_STATUS, 32'h0, s, err);
   endtask : rd_st

   task automatic wait_sw(input int k);
      repeat (k * SW) @(posedge pclk);
   endtask : wait_sw

   task automatic send(input logic [5:0] c);
      req_code <= c;
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
   endtask : send

   task automatic wait_state(input logic [1:0] s, input int max);
      int k;
      k = 0;
      do begin
         rd_st(r);
         k++;
      end while (r[1:0] !== s && k < max);
      chk(r[1:0], s);
   endtask : wait_state

   // Counts clock edges until the reference moves; gives up after a bounded span.
   task automatic gap(output int g);
      logic [7:0] prev;
      prev = reference_setpoint;
      g = 0;
      do begin
         @(posedge pclk);
         g++;
      end while (reference_setpoint === prev && g < 600);
      chk(32'(reference_setpoint !== prev), 32'h0000_0001);
   endtask : gap

   task automatic t_reset();
      chk({ov_threshold, reference_setpoint, 6'h0, pwm_enable, overvoltage_clamp}, 32'h9c00_00);
      apb(1'b0, ADDR_CTRL, 32'h0, r, e);
      chk(r, CTRL_RESET);
      apb(1'b1, ADDR_STATUS, 32'hffff_ffff, r, e);
      chk(e, 1'b0);
      apb(1'b0, 12'h008, 32'h0, r, e);
      chk(r, 32'h0000_0000);
      chk(32'(e), 32'h0000_0001);
      wait_state(2'h0, 1);
   endtask : t_reset

   task automatic t_legacy_start();
      wait_sw(20);
      wait_state(2'h0, 1);
      driver_supply_level_ok <= 1'b0;
      send(6'h1e);
      wait_sw(11);
      rd_st(r);
      chk(r[20:16], 5'h1f);
      wait_sw(4);
      rd_st(r);
      chk(r[20:0], 21'h1e_0000);
      driver_supply_level_ok <= 1'b1;
      @(posedge pclk);
      wait_state(2'h1, 1);
      wait_sw(13);
      wait_state(2'h1, 1);
      wait_sw(4);
      wait_state(2'h2, 1);
      gap(n);
      gap(n);
      chk(n, 16 * SW);
      chk({ov_threshold, 7'h0, pwm_enable}, 16'h9c00);
      wait_state(2'h3, 9000);
      repeat (2) @(posedge pclk);
      chk({reference_setpoint, ov_threshold, 7'h0, pwm_enable}, 24'h5868_01);
   endtask : t_legacy_start

   task automatic t_clamp();
      overvoltage_comp <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({overvoltage_clamp, low_side_gate_drive}, 3'h7);
      overvoltage_comp <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({overvoltage_clamp, low_side_gate_drive}, 3'h0);
      wait_state(2'h3, 1);
      chk(pwm_enable, 1'b1);
   endtask : t_clamp

   task automatic t_dyn_five();
      send(6'h1c);
      wait_sw(11);
      chk(reference_setpoint, 8'h58);
      gap(n);
      chk(reference_setpoint, 8'h5a);
      gap(n);
      chk({n[7:0], reference_setpoint}, {8'(STEP_SW_CYCLES * SW), 8'h5c});
      wait_sw(10);
      chk(reference_setpoint, 8'h5c);
   endtask : t_dyn_five

   task automatic t_alt();
      threshold_enable_input <= 1'b0;
      send(6'h1e);
      wait_sw(2);
      wait_state(2'h0, 1);
      table_select <= TABLE_ALT;
      threshold_enable_input <= 1'b1;
      wait_state(2'h2, 200);
      chk(pwm_enable, 1'b0);
      fb_below_ref <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(pwm_enable, 1'b1);
      wait_state(2'h3, 9000);
      repeat (2) @(posedge pclk);
      chk({reference_setpoint, ov_threshold}, 16'h4050);
   endtask : t_alt

   task automatic t_six();
      threshold_enable_input <= 1'b0;
      table_select <= TABLE_SIX;
      send(6'h0a);
      wait_sw(4);
      threshold_enable_input <= 1'b1;
      wait_state(2'h3, 9000);
      repeat (2) @(posedge pclk);
      chk({reference_setpoint, ov_threshold}, 16'h4353);
      send(6'h29);
      gap(n);
      chk({n <= 2 * SW + 3, reference_setpoint}, {1'b1, 8'h44});
      repeat (2) @(posedge pclk);
      chk(ov_threshold, 8'h54);
      send(6'h0a);
      gap(n);
      chk(reference_setpoint, 8'h43);
   endtask : t_six

   task automatic t_por();
      vcc_por_ok <= 1'b0;
      overvoltage_comp <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({low_side_gate_drive_oe, overvoltage_clamp}, 3'h0);
   endtask : t_por

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_legacy_start();
      t_clamp();
      t_dyn_five();
      t_alt();
      t_six();
      t_por();
      print_verdict();
   end

   // The runs above need about 30000 cycles, so three times that means a hang.
   initial begin
      repeat (90000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
endmodule : vid_reference_sequencer_tb
